// File: core/brh_arb_if.sv
`timescale 1ns/10ps
`default_nettype none
interface brh_arb_if;
  logic reqSync;
  logic ackSync;
  logic grantAllowed;
  logic grant;
  logic float;

  modport arb (
    input reqSync,
    input ackSync,
    input grantAllowed,
    output grant,
    output float
  );

  modport core (
    output reqSync,
    output ackSync,
    output grantAllowed,
    input grant,
    input float
  );
endinterface
`default_nettype wire

// File: core/brh_arbiter.sv
`timescale 1ns/10ps
`default_nettype none
`include "brh_params.svh"
module brh_arbiter import brh_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Arbitration handshake
  brh_arb_if.arb arbBus
);
  brh_arb_state_t arbState;
  brh_arb_state_t next_arbState;

  always_comb begin
    next_arbState = arbState;
    unique case (arbState)
      ARB_IDLE: begin
        if (arbBus.reqSync && arbBus.grantAllowed) begin
          next_arbState = ARB_GRANT;
        end
      end
      ARB_GRANT: begin
        if (arbBus.ackSync) begin
          next_arbState = ARB_FLOAT;
        end else if (!arbBus.reqSync) begin
          next_arbState = ARB_IDLE;
        end
      end
      ARB_FLOAT: begin
        if (!arbBus.ackSync) begin
          next_arbState = ARB_IDLE;
        end else if (arbBus.reqSync) begin
          next_arbState = ARB_REGRANT;
        end
      end
      ARB_REGRANT: begin
        if (!arbBus.ackSync) begin
          // Stay in regrant until the current master drops its acknowledge
          next_arbState = arbBus.reqSync ? ARB_GRANT : ARB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      arbState <= ARB_IDLE;
      arbBus.grant <= 1'b0;
      arbBus.float <= 1'b0;
    end else begin
      arbState <= next_arbState;
      arbBus.grant <= (next_arbState == ARB_GRANT) || (next_arbState == ARB_REGRANT);
      arbBus.float <= (next_arbState == ARB_FLOAT) || (next_arbState == ARB_REGRANT);
    end
  end

  a_idle_quiet: assert property (@(posedge clock) disable iff (!reset_n)
    (arbState == ARB_IDLE) |-> (!arbBus.grant && !arbBus.float))
    else $error("arbiter idle with grant or float set");

  a_grant_drop: assert property (@(posedge clock) disable iff (!reset_n)
    (arbState == ARB_GRANT && arbBus.ackSync) |=> (!arbBus.grant ##1 1'b1))
    else $error("grant not removed after acknowledge");

  a_float_needs_ack: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(arbBus.float) |-> $past(arbBus.ackSync))
    else $error("bus released without acknowledge");
endmodule
`default_nettype wire

// File: core/brh_bus_retry_halt.sv
`timescale 1ns/10ps
`default_nettype none
`include "brh_params.svh"
module brh_bus_retry_halt import brh_pkg::*; #(
  parameter bit RETRY_SUPPORTED = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Requests from the internal bus controller
  input wire logic cycleReq,
  input wire logic cycleInternal,
  input wire logic cycleLast,
  input wire logic cycleLocked,
  input wire logic cycleWrite,
  input wire logic [`BRH_ADDR_W-1:0] cycleAddr,
  input wire logic [`BRH_FC_W-1:0] cycleFc,
  input wire logic [`BRH_SIZE_W-1:0] cycleSize,
  input wire logic [`BRH_DATA_W-1:0] cycleWdata,
  input wire logic [`BRH_SHOW_W-1:0] showCycleEnable,
  // Answers to the internal bus controller
  output logic cycleAccept,
  output logic cycleDone,
  output logic cycleBusError,
  output logic [`BRH_DATA_W-1:0] cycleRdata,
  output logic busStopped,
  output logic interruptHold,
  // Termination and arbitration pins
  input wire logic transferAcknowledgeIn,
  input wire logic busErrorIn,
  input wire logic stopRequestIn,
  input wire logic busRequestIn,
  input wire logic grantAcknowledgeIn,
  output logic busGrantOut,
  // Address and control pins
  output logic [`BRH_ADDR_W-1:0] addrOut,
  output logic [`BRH_FC_W-1:0] fcOut,
  output logic [`BRH_SIZE_W-1:0] transferSize,
  output logic readNotWrite,
  output logic ctrlOe,
  output logic addressStrobe,
  output logic dataStrobe,
  output logic lockedCycleFlag,
  // Data pins
  input wire logic [`BRH_DATA_W-1:0] dataIn,
  output logic [`BRH_DATA_W-1:0] dataOut,
  output logic dataOe
);
  brh_arb_if arbBus ();

  brh_cyc_state_t cycState;
  brh_cyc_state_t next_cycState;
  logic [`BRH_SYNC_W-1:0] syncPair;
  logic [`BRH_CNT_W-1:0] resyncCount;
  logic busOwned;
  logic canStart;
  logic accepting;
  logic operandOpen;
  logic lastHeld;
  logic writeHeld;
  logic next_write;
  logic retryHit;

  brh_sync u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .asyncIn({busRequestIn, grantAcknowledgeIn}),
    .syncOut(syncPair)
  );

  assign arbBus.reqSync = syncPair[`BRH_SYNC_REQ_BIT];
  assign arbBus.ackSync = syncPair[`BRH_SYNC_ACK_BIT];

  brh_arbiter u_arbiter (
    .clock(clock),
    .reset_n(reset_n),
    .arbBus(arbBus)
  );

  // Requests are granted only in the idle and retry cycle states, including while stopped
  // Grant is offered only at an operand boundary or while a retry waits
  assign arbBus.grantAllowed = !lockedCycleFlag && !operandOpen
    && ((cycState == CYC_IDLE) || (cycState == CYC_RETRY))
    && !(showCycleEnable == `BRH_SHOW_ALL && cycleReq && cycleInternal);

  // Grant outstanding also blocks new external cycles, so an acknowledge never lands mid-cycle
  assign busOwned = !arbBus.grant && !arbBus.float;
  assign canStart = busOwned && !arbBus.reqSync && !stopRequestIn && !busErrorIn;
  assign accepting = (cycState == CYC_IDLE) && cycleReq && (cycleInternal || canStart);
  assign retryHit = RETRY_SUPPORTED && busErrorIn && stopRequestIn;
  assign next_write = (cycState == CYC_IDLE) ? cycleWrite : writeHeld;

  always_comb begin
    next_cycState = cycState;
    unique case (cycState)
      CYC_IDLE: begin
        if (accepting) begin
          next_cycState = cycleInternal ? CYC_INT : CYC_ADDR;
        end
      end
      CYC_ADDR: begin
        next_cycState = CYC_WAIT;
      end
      CYC_WAIT: begin
        if (retryHit) begin
          next_cycState = CYC_RETRY;
        end else if (busErrorIn || transferAcknowledgeIn) begin
          next_cycState = CYC_IDLE;
        end
      end
      CYC_RETRY: begin
        if (!busErrorIn && !stopRequestIn && busOwned) begin
          next_cycState = CYC_RESYNC;
        end
      end
      CYC_RESYNC: begin
        if (busErrorIn || stopRequestIn || !busOwned) begin
          next_cycState = CYC_RETRY;
        end else if (resyncCount == '0) begin
          next_cycState = CYC_ADDR;
        end
      end
      CYC_INT: begin
        next_cycState = CYC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cycState <= CYC_IDLE;
    end else begin
      cycState <= next_cycState;
    end
  end

  // Settling delay after error and stop both negate
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      resyncCount <= '0;
    end else if (next_cycState == CYC_RESYNC && cycState != CYC_RESYNC) begin
      resyncCount <= `BRH_CNT_W'(`BRH_RERUN_SYNC_CYC - 1);
    end else if (resyncCount != '0) begin
      resyncCount <= resyncCount - `BRH_CNT_W'(1);
    end
  end

  // Attributes of external cycles are captured once and kept through retries and stops
  // Internal cycles leave the pins alone, so a stopped bus keeps its parked address
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      addrOut <= `BRH_ADDR_RST;
      fcOut <= '0;
      transferSize <= '0;
      readNotWrite <= 1'b1;
      writeHeld <= 1'b0;
      lastHeld <= 1'b1;
      dataOut <= `BRH_DATA_RST;
    end else if (accepting && !cycleInternal) begin
      addrOut <= cycleAddr;
      fcOut <= cycleFc;
      transferSize <= cycleSize;
      readNotWrite <= !cycleWrite;
      writeHeld <= cycleWrite;
      lastHeld <= cycleLast;
      dataOut <= cycleWdata;
    end
  end

  // Locked flag rises only with an accepted external cycle, never under an outstanding grant
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lockedCycleFlag <= 1'b0;
    end else if (accepting && !cycleInternal) begin
      lockedCycleFlag <= cycleLocked;
    end else if (cycState == CYC_IDLE && !cycleLocked) begin
      lockedCycleFlag <= 1'b0;
    end
  end

  // Operand stays open until its last cycle ends, so grant waits for it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      operandOpen <= 1'b0;
    end else if (cycState == CYC_WAIT && !retryHit) begin
      if (busErrorIn) begin
        operandOpen <= 1'b0;
      end else if (transferAcknowledgeIn) begin
        operandOpen <= !lastHeld;
      end
    end
  end

  // Pin drivers: strobes and data enable from the next cycle state, ctrlOe and busGrantOut from the arbiter
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      addressStrobe <= 1'b0;
      dataStrobe <= 1'b0;
      dataOe <= 1'b0;
      ctrlOe <= 1'b1;
      busGrantOut <= 1'b0;
    end else begin
      addressStrobe <= brh_cyc_drives(next_cycState);
      dataStrobe <= brh_cyc_drives(next_cycState);
      dataOe <= brh_cyc_drives(next_cycState) && next_write;
      ctrlOe <= !arbBus.float;
      busGrantOut <= arbBus.grant;
    end
  end

  // Answers to the controller
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cycleAccept <= 1'b0;
      cycleDone <= 1'b0;
      cycleBusError <= 1'b0;
      cycleRdata <= `BRH_DATA_RST;
    end else begin
      cycleAccept <= accepting;
      cycleDone <= (cycState == CYC_INT)
        || (cycState == CYC_WAIT && !busErrorIn && transferAcknowledgeIn);
      cycleBusError <= (cycState == CYC_WAIT) && busErrorIn && !retryHit;
      if (cycState == CYC_WAIT && !busErrorIn && transferAcknowledgeIn && !writeHeld) begin
        cycleRdata <= dataIn;
      end
    end
  end

  // Stopped means the stop line is up, bus error is not, and the cycle state is idle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busStopped <= 1'b0;
      interruptHold <= 1'b0;
    end else begin
      busStopped <= stopRequestIn && !busErrorIn && (cycState == CYC_IDLE);
      interruptHold <= stopRequestIn;
    end
  end

  a_retry_entry: assert property (@(posedge clock) disable iff (!reset_n)
    (RETRY_SUPPORTED && cycState == CYC_WAIT && busErrorIn && stopRequestIn) |=> (cycState == CYC_RETRY))
    else $error("retry not entered");

  a_error_noretry: assert property (@(posedge clock) disable iff (!reset_n)
    (!RETRY_SUPPORTED && cycState == CYC_WAIT && busErrorIn) |=> (cycleBusError && cycState == CYC_IDLE))
    else $error("bus error not reported");

  a_retry_quiet: assert property (@(posedge clock) disable iff (!reset_n)
    (cycState == CYC_RETRY && (busErrorIn || stopRequestIn)) |=> (!addressStrobe && cycState == CYC_RETRY))
    else $error("cycle started during retry");

  a_rerun_same: assert property (@(posedge clock) disable iff (!reset_n)
    (cycState == CYC_RETRY) |=> ($stable(addrOut) && $stable(dataOut) && $stable(readNotWrite)))
    else $error("retry changed cycle attributes");

  a_retry_delay: assert property (@(posedge clock) disable iff (!reset_n)
    (cycState == CYC_RETRY ##1 cycState == CYC_RESYNC) |-> (cycState != CYC_ADDR)[*2])
    else $error("rerun before settling delay");

  a_lock_retry: assert property (@(posedge clock) disable iff (!reset_n)
    (cycState == CYC_RETRY || cycState == CYC_RESYNC) |=> $stable(lockedCycleFlag))
    else $error("locked flag changed during retry");

  a_lock_nogrant: assert property (@(posedge clock) disable iff (!reset_n)
    (lockedCycleFlag && !busGrantOut && !arbBus.grant) |=> !arbBus.grant ##1 !busGrantOut)
    else $error("grant while locked");

  a_stop_holds: assert property (@(posedge clock) disable iff (!reset_n)
    (cycState == CYC_IDLE && stopRequestIn) |=> (cycState != CYC_ADDR && !addressStrobe))
    else $error("external cycle started while stopped");

  a_stopped_float: assert property (@(posedge clock) disable iff (!reset_n)
    (cycState == CYC_IDLE && stopRequestIn) |=> (!dataOe && !dataStrobe && $stable(addrOut)))
    else $error("pins not parked while stopped");

  a_int_hold: assert property (@(posedge clock) disable iff (!reset_n)
    busStopped |-> interruptHold)
    else $error("interrupts open while stopped");

  a_retry_strobes_off: assert property (@(posedge clock) disable iff (!reset_n)
    (cycState == CYC_WAIT && retryHit) |=> (!addressStrobe && !dataStrobe && !dataOe))
    else $error("strobes still driven after retry termination");

  a_cycle_owned: assert property (@(posedge clock) disable iff (!reset_n)
    (cycState == CYC_ADDR || cycState == CYC_WAIT) |-> (busOwned && ctrlOe))
    else $error("external cycle run without bus ownership");

  a_rerun_control: assert property (@(posedge clock) disable iff (!reset_n)
    (cycState == CYC_RETRY || cycState == CYC_RESYNC) |=> ($stable(fcOut) && $stable(transferSize)))
    else $error("retry changed function code or size");

  a_float_unlocked: assert property (@(posedge clock) disable iff (!reset_n)
    arbBus.float |-> !lockedCycleFlag)
    else $error("bus released while locked");

  a_grant_boundary: assert property (@(posedge clock) disable iff (!reset_n)
    (!arbBus.grant && !arbBus.float && !arbBus.grantAllowed) |=> !arbBus.grant)
    else $error("grant outside an operand boundary");

  a_yield_request: assert property (@(posedge clock) disable iff (!reset_n)
    (cycState == CYC_IDLE && arbBus.reqSync && cycleReq && !cycleInternal) |=> (cycState != CYC_ADDR))
    else $error("own cycle started over a pending request");

  a_grant_no_float: assert property (@(posedge clock) disable iff (!reset_n)
    (arbBus.grant && !arbBus.ackSync) |=> !arbBus.float)
    else $error("bus floated without acknowledge");

  a_regrant_pending: assert property (@(posedge clock) disable iff (!reset_n)
    (arbBus.float && !arbBus.grant && arbBus.ackSync && arbBus.reqSync) |=> arbBus.grant)
    else $error("pending request not granted again");

  a_internal_runs: assert property (@(posedge clock) disable iff (!reset_n)
    (cycState == CYC_IDLE && cycleReq && cycleInternal) |=> (cycState == CYC_INT))
    else $error("internal cycle held back");

  a_sync_depth: assert property (@(posedge clock) disable iff (!reset_n)
    (arbBus.reqSync == $past(busRequestIn, 2)) && (arbBus.ackSync == $past(grantAcknowledgeIn, 2)))
    else $error("synchroniser latency wrong");

  a_halt_pins: assert property (@(posedge clock) disable iff (!reset_n)
    busStopped |-> (!addressStrobe && !dataStrobe && !dataOe))
    else $error("strobes or data driven while stopped");

  a_float_holds: assert property (@(posedge clock) disable iff (!reset_n)
    arbBus.float |=> ($stable(addrOut) && $stable(fcOut) && $stable(transferSize) && $stable(readNotWrite)))
    else $error("held address lost while bus lent");
endmodule
`default_nettype wire

// File: core/brh_params.svh
`ifndef BRH_PARAMS_SVH
`define BRH_PARAMS_SVH

// Clock period and the settling time allowed before a retried cycle is rerun
`define BRH_CLK_PERIOD_NS 5
`define BRH_RERUN_SYNC_NS 10
`define BRH_RERUN_SYNC_CYC ((`BRH_RERUN_SYNC_NS + `BRH_CLK_PERIOD_NS - 1) / `BRH_CLK_PERIOD_NS)

// Widths of the bus fields
`define BRH_ADDR_W 24
`define BRH_FC_W 3
`define BRH_SIZE_W 2
`define BRH_DATA_W 16
`define BRH_SHOW_W 2
`define BRH_SYNC_W 2
`define BRH_CNT_W 4

// Field positions in the synchroniser pair
`define BRH_SYNC_REQ_BIT 1
`define BRH_SYNC_ACK_BIT 0

// Reset values and the show-all code
`define BRH_ADDR_RST 24'h00_0000
`define BRH_DATA_RST 16'h0000
`define BRH_SHOW_ALL 2'h3

`endif

// File: core/brh_pkg.sv
`default_nettype none
package brh_pkg;

  typedef enum logic [2:0] {
    CYC_IDLE,
    CYC_ADDR,
    CYC_WAIT,
    CYC_RETRY,
    CYC_RESYNC,
    CYC_INT
  } brh_cyc_state_t;

  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_GRANT,
    ARB_FLOAT,
    ARB_REGRANT
  } brh_arb_state_t;

  // Strobes and write data are driven only in these cycle states
  function automatic logic brh_cyc_drives(input brh_cyc_state_t s);
    return (s == CYC_ADDR) || (s == CYC_WAIT);
  endfunction

endpackage
`default_nettype wire

// File: core/brh_sync.sv
`timescale 1ns/10ps
`default_nettype none
`include "brh_params.svh"
module brh_sync import brh_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Levels
  input wire logic [`BRH_SYNC_W-1:0] asyncIn,
  output logic [`BRH_SYNC_W-1:0] syncOut
);
  logic [`BRH_SYNC_W-1:0] stage1;

  // Two flops: valid by the second edge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule
`default_nettype wire

// File: test/brh_ext_partner.sv
`timescale 1ns/10ps
`default_nettype none
module brh_ext_partner #(
  parameter int ERR_HOLD = 12,
  parameter int ACK_HOLD = 8,
  parameter logic [15:0] READ_DATA = 16'hc3a5
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Bench controls
  input wire logic wantBus,
  input wire logic noAck,
  input wire logic armRetry,
  // Device pins
  input wire logic addressStrobe,
  input wire logic busGrantOut,
  input wire logic lockedCycleFlag,
  output logic transferAcknowledgeIn,
  output logic busErrorIn,
  output logic stopOut,
  output logic busRequestIn,
  output logic grantAcknowledgeIn,
  output logic [15:0] dataIn
);
  int errCnt;
  int ackCnt;
  logic retryUsed;
  logic wantPrev;

  // Cycle termination
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      transferAcknowledgeIn <= 1'b0;
      busErrorIn <= 1'b0;
      stopOut <= 1'b0;
      dataIn <= 16'h0000;
      errCnt <= 0;
      retryUsed <= 1'b0;
    end else begin
      transferAcknowledgeIn <= 1'b0;
      // Undriven data wanders so a stale word never passes for a read
      dataIn <= ~dataIn;
      if (!armRetry) begin
        retryUsed <= 1'b0;
      end
      if (errCnt != 0) begin
        errCnt <= errCnt - 1;
        if (errCnt == 1) begin
          busErrorIn <= 1'b0;
          stopOut <= 1'b0;
        end
      end else if (addressStrobe && !transferAcknowledgeIn) begin
        if (armRetry && !retryUsed) begin
          busErrorIn <= 1'b1;
          // A master that wants the bus inside a locked sequence leaves stop off
          stopOut <= !(lockedCycleFlag && wantBus);
          errCnt <= ERR_HOLD;
          retryUsed <= 1'b1;
        end else begin
          transferAcknowledgeIn <= 1'b1;
          dataIn <= READ_DATA;
        end
      end
    end
  end

  // Outside master, one request per rising edge of wantBus
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busRequestIn <= 1'b0;
      grantAcknowledgeIn <= 1'b0;
      ackCnt <= 0;
      wantPrev <= 1'b0;
    end else begin
      wantPrev <= wantBus;
      if (wantBus && !wantPrev) begin
        busRequestIn <= 1'b1;
      end else if (busRequestIn && busGrantOut && !grantAcknowledgeIn) begin
        busRequestIn <= 1'b0;
        grantAcknowledgeIn <= !noAck;
        ackCnt <= ACK_HOLD;
      end else if (ackCnt != 0) begin
        ackCnt <= ackCnt - 1;
        grantAcknowledgeIn <= grantAcknowledgeIn && (ackCnt != 1);
      end
    end
  end
endmodule
`default_nettype wire

// File: test/tb_bus_retry_halt_arbitration.sv
`timescale 1ns/10ps
`default_nettype none
module tb_bus_retry_halt_arbitration;
  localparam logic [15:0] RD = 16'hc3a5;
  logic clock = 1'b0, reset_n = 1'b0;
  logic cycleReq = 1'b0, cycleInternal = 1'b0, cycleLast = 1'b1, cycleLocked = 1'b0, cycleWrite = 1'b0;
  logic [23:0] cycleAddr = 24'h00_0000;
  logic [2:0] cycleFc = 3'h0;
  logic [1:0] cycleSize = 2'h0;
  logic [15:0] cycleWdata = 16'h0000;
  logic stopBench = 1'b0, wantBus = 1'b0, noAck = 1'b0, armRetry = 1'b0;
  logic cycleAccept, cycleDone, cycleBusError, busStopped, interruptHold, busGrantOut;
  logic ack, bus_error_in, stopPartner, stopRequestIn, busReq, grantAck, readNotWrite, ctrlOe;
  logic addressStrobe, dataStrobe, lockedCycleFlag, dataOe, nrBusError;
  logic [15:0] cycleRdata, dataIn, dataOut;
  logic [23:0] addrOut;
  logic [2:0] fcOut;
  logic [1:0] transferSize;
  int errors = 0, testsRun = 0, cycles = 0, floatCycles = 0, nrErrors = 0;

  assign stopRequestIn = stopBench | stopPartner;

  brh_bus_retry_halt dut (
    .clock(clock), .reset_n(reset_n), .cycleReq(cycleReq), .cycleInternal(cycleInternal),
    .cycleLast(cycleLast), .cycleLocked(cycleLocked), .cycleWrite(cycleWrite), .cycleAddr(cycleAddr),
    .cycleFc(cycleFc), .cycleSize(cycleSize), .cycleWdata(cycleWdata), .showCycleEnable(2'b00),
    .cycleAccept(cycleAccept), .cycleDone(cycleDone), .cycleBusError(cycleBusError),
    .cycleRdata(cycleRdata), .busStopped(busStopped), .interruptHold(interruptHold),
    .transferAcknowledgeIn(ack), .busErrorIn(bus_error_in), .stopRequestIn(stopRequestIn),
    .busRequestIn(busReq), .grantAcknowledgeIn(grantAck), .busGrantOut(busGrantOut),
    .addrOut(addrOut), .fcOut(fcOut), .transferSize(transferSize), .readNotWrite(readNotWrite),
    .ctrlOe(ctrlOe), .addressStrobe(addressStrobe), .dataStrobe(dataStrobe),
    .lockedCycleFlag(lockedCycleFlag), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe)
  );

  brh_ext_partner far (
    .clock(clock), .reset_n(reset_n), .wantBus(wantBus), .noAck(noAck), .armRetry(armRetry),
    .addressStrobe(addressStrobe), .busGrantOut(busGrantOut), .lockedCycleFlag(lockedCycleFlag),
    .transferAcknowledgeIn(ack),
    .busErrorIn(bus_error_in), .stopOut(stopPartner), .busRequestIn(busReq),
    .grantAcknowledgeIn(grantAck), .dataIn(dataIn)
  );

  // Same stimulus into a build without retry: error plus stop must end as a bus error
  brh_bus_retry_halt #(.RETRY_SUPPORTED(1'b0)) dut_noretry (
    .clock(clock), .reset_n(reset_n), .cycleReq(cycleReq), .cycleInternal(cycleInternal),
    .cycleLast(cycleLast), .cycleLocked(cycleLocked), .cycleWrite(cycleWrite), .cycleAddr(cycleAddr),
    .cycleFc(cycleFc), .cycleSize(cycleSize), .cycleWdata(cycleWdata), .showCycleEnable(2'b00),
    .cycleAccept(), .cycleDone(), .cycleBusError(nrBusError), .cycleRdata(), .busStopped(), .interruptHold(),
    .transferAcknowledgeIn(ack), .busErrorIn(bus_error_in), .stopRequestIn(stopRequestIn),
    .busRequestIn(busReq), .grantAcknowledgeIn(grantAck), .busGrantOut(),
    .addrOut(), .fcOut(), .transferSize(), .readNotWrite(), .ctrlOe(), .addressStrobe(), .dataStrobe(),
    .lockedCycleFlag(), .dataIn(dataIn), .dataOut(), .dataOe()
  );

  always #2.5 clock = ~clock;

  // Ceiling is about a hundred times the length of all scenarios together
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (ctrlOe === 1'b0) begin
      floatCycles <= floatCycles + 1;
    end
    if (nrBusError === 1'b1) begin
      nrErrors <= nrErrors + 1;
    end
    if (cycles == 20000) begin
      errors++;
      $display("MISMATCH t=%0t run timed out", $time);
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_for(ref logic sig, input logic val, input int n, input string what);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      if (sig === val) break;
    end
    chk(sig, val, what);
  endtask

  // stopFor: edge at which the bench lifts its stop request (-1 leaves it alone)
  task automatic run_cycle(input logic wr, input logic intl, input logic [23:0] a, input logic [15:0] d,
      input int stopFor, output int strobes);
    strobes = 0;
    cycleWrite <= wr;
    cycleInternal <= intl;
    cycleAddr <= a;
    cycleWdata <= d;
    cycleFc <= 3'h5;
    cycleSize <= 2'h2;
    cycleReq <= 1'b1;
    for (int i = 0; i < 300; i++) begin
      @(posedge clock);
      if (i == stopFor) stopBench <= 1'b0;
      if (cycleAccept === 1'b1) begin
        cycleReq <= 1'b0;
        chk(i > stopFor, 1'b1, "accepted while stopped");
      end
      if (addressStrobe === 1'b1) begin
        strobes++;
        chk(addrOut, a, "address");
        chk({fcOut, transferSize, readNotWrite}, {3'h5, 2'h2, ~wr}, "control");
        if (wr) chk(dataOut, d, "write data");
        chk(ctrlOe, 1'b1, "strobe while floated");
        if (cycleLocked) chk(lockedCycleFlag, 1'b1, "lock flag");
      end
      if (lockedCycleFlag === 1'b1) chk(busGrantOut, 1'b0, "grant while locked");
      if (cycleDone === 1'b1 || cycleBusError === 1'b1) begin
        chk(cycleBusError, 1'b0, "bus error");
        if (!wr && !intl) chk(cycleRdata, RD, "read data");
        return;
      end
    end
    chk(1'b0, 1'b1, "cycle never ended");
  endtask

  task automatic t_basic();
    int s;
    chk({busGrantOut, ctrlOe}, 2'b01, "idle arbiter");
    run_cycle(1'b1, 1'b0, 24'h12_3456, 16'hbeef, 0, s);
    chk(s, 2, "write strobes");
    run_cycle(1'b0, 1'b0, 24'hab_cdef, 16'h0000, 0, s);
    chk(s, 2, "read strobes");
    $display("test basic done");
  endtask

  task automatic t_retry();
    int s;
    int n;
    n = nrErrors;
    armRetry <= 1'b1;
    run_cycle(1'b1, 1'b0, 24'h00_0ff0, 16'h1234, 0, s);
    chk(s, 4, "one rerun");
    chk(nrErrors - n, 1, "no-retry build bus error");
    armRetry <= 1'b0;
    $display("test retry done");
  endtask

  task automatic t_halt();
    int s;
    stopBench <= 1'b1;
    repeat (3) @(posedge clock);
    chk({busStopped, interruptHold}, 2'b11, "stopped");
    chk(addrOut, 24'h00_0ff0, "held address");
    chk({addressStrobe, dataStrobe, dataOe}, 3'b000, "quiet pins");
    run_cycle(1'b0, 1'b1, 24'h00_0100, 16'h0000, -1, s);
    chk(s, 0, "internal while stopped");
    run_cycle(1'b0, 1'b0, 24'h00_0200, 16'h0000, 12, s);
    chk(s, 2, "external after stop");
    $display("test halt done");
  endtask

  task automatic t_arb();
    int s;
    stopBench <= 1'b1;
    wantBus <= 1'b1;
    wait_for(busGrantOut, 1'b1, 10, "grant while stopped");
    wantBus <= 1'b0;
    wait_for(ctrlOe, 1'b0, 10, "float");
    @(posedge clock);
    chk(busGrantOut, 1'b0, "grant removed");
    wait_for(ctrlOe, 1'b1, 20, "bus returned");
    chk(addrOut, 24'h00_0200, "restored address");
    run_cycle(1'b1, 1'b0, 24'h00_0300, 16'h5a5a, 4, s);
    chk(s, 2, "cycle after return");
    $display("test arbitration done");
  endtask

  task automatic t_noack();
    int s;
    noAck <= 1'b1;
    wantBus <= 1'b1;
    wait_for(busGrantOut, 1'b1, 10, "grant");
    wantBus <= 1'b0;
    wait_for(busGrantOut, 1'b0, 10, "grant withdrawn");
    chk(ctrlOe, 1'b1, "kept bus");
    run_cycle(1'b0, 1'b0, 24'h00_0400, 16'h0000, 0, s);
    chk(s, 2, "own cycle");
    noAck <= 1'b0;
    $display("test no acknowledge done");
  endtask

  task automatic t_locked();
    int s;
    cycleLocked <= 1'b1;
    cycleLast <= 1'b0;
    armRetry <= 1'b1;
    run_cycle(1'b0, 1'b0, 24'h00_0500, 16'h0000, 0, s);
    chk(s, 4, "locked read retried");
    armRetry <= 1'b0;
    cycleLast <= 1'b1;
    wantBus <= 1'b1;
    run_cycle(1'b1, 1'b0, 24'h00_0500, 16'h0f0f, 0, s);
    chk(s, 2, "locked write");
    chk(busGrantOut, 1'b0, "no grant in lock");
    wantBus <= 1'b0;
    cycleLocked <= 1'b0;
    wait_for(busGrantOut, 1'b1, 20, "grant after unlock");
    wait_for(ctrlOe, 1'b0, 10, "float after unlock");
    wait_for(ctrlOe, 1'b1, 30, "bus back");
    $display("test locked done");
  endtask

  task automatic t_retry_grant();
    int s;
    int f;
    f = floatCycles;
    armRetry <= 1'b1;
    wantBus <= 1'b1;
    run_cycle(1'b1, 1'b0, 24'h00_0600, 16'h3c3c, 0, s);
    chk(s, 4, "rerun after lending");
    chk(floatCycles > f, 1'b1, "bus lent during retry");
    armRetry <= 1'b0;
    wantBus <= 1'b0;
    $display("test retry with grant done");
  endtask

  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    t_basic();
    t_retry();
    t_halt();
    t_arb();
    t_noack();
    t_locked();
    t_retry_grant();
    complete_run();
  end
endmodule
`default_nettype wire
